// ==== sim/sdram_write_crc_timing_tb_top.sv ====
// Purpose: Bench for both write link ends joined back to back.
// Assumes: Device config inputs mirror the controller control register.
// Notes:   Deliberate strobe faults need a second link and are not covered here.
`timescale 1ns/10ps
`default_nettype none
`include "wcrc_defs.svh"

module sdram_write_crc_timing_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0, crc_en_i = 1'b0;
  logic [3:0]  addr_i = 4'h0, wr_bank_o, rd_bank_o;
  logic [31:0] wdata_i = 32'h0, rdata_o, r;
  logic [1:0]  burst_mode_i = 2'h0;
  logic [4:0]  cwl_i = 5'h09;
  logic        wr_done_o, wr_bad_o, crc_err_o, suspect_o, rd_valid_o;
  logic [63:0] rd_data_o;
  int          num_errors = 0, checks_done = 0, cyc = 0;

  wcrc_link_if link ();
  wcrc_ctrl i_wcrc_ctrl (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .link);
  wcrc_dram i_wcrc_dram (.clk_i, .rst_i, .link, .burst_mode_i, .crc_en_i, .cwl_i, .wr_done_o,
    .wr_bank_o, .wr_bad_o, .crc_err_o, .suspect_o, .rd_valid_o, .rd_bank_o, .rd_data_o);
  wcrc_link_sva i_wcrc_link_sva (.clk_i, .rst_i, .ck(link.ck), .dqs(link.dqs),
    .dqs_en(link.dqs_en), .cmd(link.cmd), .dq(link.dq));

  // Core clock at 50 MHz.
  always #10 clk_i = ~clk_i;

  task automatic report_and_stop();
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // A hang costs a mismatch; the tests need well under this many cycles.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken mid-cycle.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  function automatic logic [63:0] pat(input logic [3:0] b);
    return {16{b}} ^ 64'hF0E1_D2C3_B4A5_9687;
  endfunction

  task automatic cfg(input logic [1:0] m, input logic c, p, input logic [4:0] w,
                     input logic [3:0] s);
    wr(`A_CTRL, {12'h000, s, 3'h0, w, 3'h0, p, 1'b0, c, m});
    burst_mode_i <= m;
    crc_en_i <= c;
    cwl_i <= (p && w < 5'h0A) ? 5'h0A : w;
  endtask

  // A second command while one is pending is dropped, so wait for the slot to free.
  task automatic drain();
    int i;
    i = 0;
    do begin
      rd(`A_STAT, r);
      i++;
    end while (r[0] !== 1'b0 && i < 50);
    cmp({63'h0, r[0]}, 64'h0);
  endtask

  task automatic send(input logic [3:0] b, input logic chop);
    logic [63:0] v;
    v = pat(b);
    wr(`A_DLO, v[31:0]);
    wr(`A_DHI, v[63:32]);
    wr(`A_CMD, {22'h0, 1'b0, chop, b, 1'b0, wcrc_pkg::CMD_WR});
    drain();
  endtask

  task automatic wait_done(input logic [3:0] b);
    int i;
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (wr_done_o !== 1'b1 && i < 800);
    cmp({60'h0, wr_done_o, wr_bank_o[3:1]}, {60'h0, 1'b1, b[3:1]});
    cmp({60'h0, wr_bank_o[0], crc_err_o, wr_bad_o, suspect_o}, {60'h0, b[0], 3'h0});
  endtask

  task automatic readback(input logic [3:0] b, input logic [63:0] m);
    int i;
    wr(`A_CMD, {22'h0, 2'b00, b, 1'b0, wcrc_pkg::CMD_RD});
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (rd_valid_o !== 1'b1 && i < 800);
    cmp(rd_data_o & m, pat(b) & m);
    cmp({59'h0, rd_valid_o, rd_bank_o}, {59'h0, 1'b1, b});
  endtask

  // Precharge-all once recovery has run out, then a flush through the control register.
  task automatic t_close();
    wr(`A_CMD, {29'h0, wcrc_pkg::CMD_PREA});
    drain();
    cmp({62'h0, r[5], suspect_o}, 64'h0);
    wr(`A_CTRL, 32'h8005_0900);
    rd(`A_CTRL, r);
    cmp({32'h0, r}, {32'h0, `CTRL_RST});
  endtask

  task automatic t_reset();
    rd(`A_CTRL, r);
    cmp({32'h0, r}, {32'h0, `CTRL_RST});
    rd(`A_TIME, r);
    cmp({32'h0, r}, {32'h0, `TIME_RST});
    rd(4'hF, r);
    cmp({32'h0, r}, 64'h0);
  endtask

  // Each mode once, mode 1 with both chop levels; chopped bursts keep only the low four bytes.
  task automatic t_modes();
    logic [1:0] md [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    logic       ch [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      cfg(md[i], 1'b0, 1'b0, 5'h09, 4'h5);
      send(4'(i + 2), ch[i]);
      wait_done(4'(i + 2));
      readback(4'(i + 2), (i > 1) ? 64'hFFFF_FFFF : '1);
    end
  endtask

  // Two checksum writes to different groups at the given spacing, one full and one chopped.
  task automatic t_crc(input logic [3:0] s, input logic p);
    cfg(2'h1, 1'b1, p, 5'h09, s);
    send(4'h1, 1'b1);
    send(4'h6, 1'b0);
    wait_done(4'h1);
    wait_done(4'h6);
    readback(4'h1, '1);
    readback(4'h6, 64'hFFFF_FFFF);
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_modes();
    t_crc(4'h5, 1'b0);
    t_crc(4'h6, 1'b0);
    t_crc(4'h7, 1'b1);
    t_close();
    report_and_stop();
  end
endmodule

`default_nettype wire

// ==== sim/wcrc_link_sva.sv ====
// Purpose: Checker on the write link wires between the two ends.
// Assumes: The core clock samples every link wire; the controller drives them from flops.
// Notes:   Counters stand in for long repetitions, which would slow the tools.
`timescale 1ns/10ps
`default_nettype none

module wcrc_link_sva (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ck,
  input  wire logic       dqs,
  input  wire logic       dqs_en,
  input  wire logic [2:0] cmd,
  input  wire logic [7:0] dq
);
  logic       dqs_q;
  logic [2:0] cmd_q;
  logic [5:0] beats_q, beats_d;
  logic [7:0] gap_q, gap_d;
  logic       new_wr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Beats are counted per strobe window; the write gap saturates so idle time never wraps.
  always_comb begin
    new_wr  = (cmd == wcrc_pkg::CMD_WR) && (cmd_q != wcrc_pkg::CMD_WR);
    beats_d = dqs_en ? beats_q + {5'h00, dqs != dqs_q} : 6'h00;
    gap_d   = new_wr ? 8'h01 : ((gap_q == 8'hFF) ? 8'hFF : gap_q + 8'h01);
  end

  // Helper state registers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dqs_q   <= 1'b0;
      cmd_q   <= 3'h0;
      beats_q <= 6'h00;
      gap_q   <= 8'hFF;
    end else begin
      dqs_q   <= dqs;
      cmd_q   <= cmd;
      beats_q <= beats_d;
      gap_q   <= gap_d;
    end
  end

  a_ck_period: assert property ($rose(ck) |-> ##8 $rose(ck))
    else $error("link clock period wrong");
  a_cmd_at_fall: assert property ($changed(cmd) |-> $fell(ck))
    else $error("command changed off the link clock fall");
  a_strobe_off: assert property (!dqs_en && !$past(dqs_en) |-> !dqs)
    else $error("strobe high outside its window");
  a_strobe_window: assert property ($changed(dqs) |-> dqs_en || $past(dqs_en))
    else $error("strobe toggled outside its window");
  a_preamble_quiet: assert property ($rose(dqs_en) |=> $stable(dqs) [*8])
    else $error("strobe toggled during preamble");
  a_beat_count: assert property ($fell(dqs_en) |-> beats_q >= 6'h04 && !beats_q[0])
    else $error("strobe window held a bad beat count");
  a_data_steady: assert property (dqs_en && $changed(dqs) |-> $stable(dq))
    else $error("data moved at a strobe edge");
  a_wr_spacing: assert property (new_wr |-> gap_q >= 8'h28)
    else $error("writes closer than five link clocks");

  c_wr_seen: cover property (new_wr);
  c_window: cover property ($fell(dqs_en) && beats_q == 6'h0A);
  c_seamless: cover property (new_wr && gap_q == 8'h28);
endmodule

`default_nettype wire

// ==== src/wcrc_ctrl.sv ====
// Purpose: Controller end: issues commands and drives write data.
// Assumes: Software writes the data words, then a command.
// Notes:   A second command while one waits is ignored.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module wcrc_ctrl #(
  parameter int DEPTH = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [31:0] rdata_o,
  wcrc_link_if.ctrl        link
);
  localparam int HALF = `CK_HALF_CLKS;
  localparam int PW   = $clog2(DEPTH);

  logic [1:0]  div_q, div_d;
  logic        ck_q, ck_d, dqs_q, dqs_d, en_q, en_d, beat_q, beat_d;
  logic [7:0]  h_q, h_d, dq_q, dq_d;
  logic [2:0]  cmd_q, cmd_d;
  logic [3:0]  bank_q, bank_d, lb_q, lb_d, space_q, space_d;
  logic        chop_q, chop_d, ap_q, ap_d, arm_q, arm_d, req_q, req_d;
  logic [31:0] ctrl_q, ctrl_d, time_q, time_d, cmdr_q, cmdr_d, rdata_q, rdata_d;
  logic [63:0] data_q, data_d;
  logic [7:0]  rec_q, rec_d;
  logic [3:0]  rbank_q, rbank_d, wtrs_q, wtrs_d, wtrl_q, wtrl_d;
  logic [1:0]  wbg_q, wbg_d;
  logic [7:0]  qs_q [DEPTH], qs_d [DEPTH];
  logic [3:0]  qn_q [DEPTH], qn_d [DEPTH], qb_q [DEPTH], qb_d [DEPTH];
  logic [3:0]  qk_q [DEPTH], qk_d [DEPTH];
  logic [63:0] qd_q [DEPTH], qd_d [DEPTH];
  logic [7:0]  qc_q [DEPTH], qc_d [DEPTH];
  logic [PW-1:0] rp_q, rp_d, wp_q, wp_d, sel;
  logic [PW:0]   cnt_q, cnt_d;
  logic        tick, mid, rise, fall, pop, push, cdm, vsel;
  logic [4:0]  write_cas_latency;
  logic [3:0]  space;
  logic [7:0]  off;
  logic [63:0] wd;
  wcrc_pkg::burst_t b;

  // Next state of clock divider, commands, data queue and timers.
  always_comb begin
    div_d = div_q; ck_d = ck_q; h_d = h_q; cmd_d = cmd_q; bank_d = bank_q;
    chop_d = chop_q; ap_d = ap_q; space_d = space_q; req_d = req_q;
    ctrl_d = ctrl_q; time_d = time_q; cmdr_d = cmdr_q; data_d = data_q;
    rec_d = rec_q; rbank_d = rbank_q; wtrs_d = wtrs_q; wtrl_d = wtrl_q;
    wbg_d = wbg_q; lb_d = lb_q; dq_d = dq_q; dqs_d = dqs_q; en_d = en_q;
    beat_d = beat_q; qs_d = qs_q; qn_d = qn_q; qb_d = qb_q; qk_d = qk_q;
    qd_d = qd_q; qc_d = qc_q; rp_d = rp_q; wp_d = wp_q; pop = 1'b0; push = 1'b0;
    off = 8'h00; sel = rp_q; vsel = 1'b0;
    tick = (div_q == 2'(HALF - 1));
    mid  = (div_q == 2'(HALF / 2 - 1));
    rise = tick & ~ck_q;
    fall = tick & ck_q;
    cdm  = ctrl_q[`F_CRC] & ctrl_q[`F_DM];
    write_cas_latency  = ctrl_q[`F_CWL];
    if (ctrl_q[`F_PRE2] && write_cas_latency < `CWL_LOWEST + 5'h01) write_cas_latency = `CWL_LOWEST + 5'h01;
    space = ctrl_q[`F_SPACE];
    if (ctrl_q[`F_PRE2] && space == `SPACING_SHORT) space = `SPACING_PRE2;
    b  = wcrc_pkg::burst_select(ctrl_q[`F_BMODE], cmdr_q[`F_CCHOP]);
    wd = (b == wcrc_pkg::BURST_EIGHT) ? data_q : {32'hFFFF_FFFF, data_q[31:0]};
    div_d = tick ? 2'h0 : div_q + 2'h1;
    if (tick) begin
      ck_d = ~ck_q;
      h_d  = h_q + 8'h01;
    end
    // Commands change on the falling link edge, sampled at the next rise.
    if (fall) begin
      cmd_d = wcrc_pkg::CMD_NOP;
      if (space_q != 4'h0) space_d = space_q - 4'h1;
      if (req_q) begin
        unique case (cmdr_q[`F_CTYPE])
          wcrc_pkg::CMD_WR: if (space_q == 4'h0 && cnt_q < (PW+1)'(DEPTH)) begin
            push = 1'b1;
            qs_d[wp_q] = h_q + 8'h02 + {2'b00, write_cas_latency, 1'b0};
            qn_d[wp_q] = wcrc_pkg::slot_beats(b, ctrl_q[`F_CRC]);
            qk_d[wp_q] = (b == wcrc_pkg::BURST_EIGHT) ? 4'h8 : 4'h4;
            qb_d[wp_q] = cmdr_q[`F_CBANK];
            qd_d[wp_q] = wd;
            qc_d[wp_q] = wcrc_pkg::crc8(wd);
            wp_d = wp_q + PW'(1);
            space_d = space - 4'h1;
          end
          wcrc_pkg::CMD_RD:
            push = (cmdr_q[7:6] == wbg_q) ? (wtrl_q == 4'h0) : (wtrs_q == 4'h0);
          wcrc_pkg::CMD_PRE:
            push = (cmdr_q[`F_CBANK] != rbank_q) || (rec_q == 8'h00);
          wcrc_pkg::CMD_PREA:
            push = (rec_q == 8'h00) && (cnt_q == '0) && !arm_q;
          default: push = 1'b1;
        endcase
        if (push) begin
          req_d = 1'b0;
          cmd_d = cmdr_q[`F_CTYPE];
          bank_d = cmdr_q[`F_CBANK];
          chop_d = cmdr_q[`F_CCHOP];
          ap_d = cmdr_q[`F_CAP];
        end
        push = push && (cmdr_q[`F_CTYPE] == wcrc_pkg::CMD_WR);
      end
    end
    // Data beats follow the half link clock; a back-to-back burst keeps the strobe on.
    if (tick) begin
      off = h_d - qs_q[rp_q];
      if (cnt_q != '0 && off == {4'h0, qn_q[rp_q]}) begin
        pop = 1'b1;
        lb_d = qb_q[rp_q];
        rp_d = rp_q + PW'(1);
      end
      sel  = pop ? rp_q + PW'(1) : rp_q;
      vsel = (cnt_q > (pop ? (PW+1)'(1) : (PW+1)'(0)));
      off  = h_d - qs_q[sel];
      beat_d = vsel && off < {4'h0, qn_q[sel]};
      en_d = vsel && $signed(off) >= (ctrl_q[`F_PRE2] ? -8'sd4 : -8'sd2);
      if (off < {4'h0, qk_q[sel]}) dq_d = qd_q[sel][{off[2:0], 3'b000} +: 8];
      else if (off == {4'h0, qn_q[sel]} - 8'h02) dq_d = qc_q[sel];
      else dq_d = ~qc_q[sel];
      if (!en_d) dqs_d = 1'b0;
    end
    if (mid && beat_q) dqs_d = ~dqs_q;
    // Recovery and turnaround start at the first rise after the last beat.
    arm_d = (arm_q | pop) & ~rise;
    if (rise) begin
      if (arm_q | pop) begin
        rbank_d = pop ? qb_q[rp_q] : lb_q;
        wbg_d = rbank_d[3:2];
        rec_d  = cdm ? time_q[`F_TWR_CDM] : time_q[`F_TWR];
        wtrs_d = cdm ? time_q[`F_WTRS_CDM] : time_q[`F_WTR_S];
        wtrl_d = cdm ? time_q[`F_WTRL_CDM] : time_q[`F_WTR_L];
      end else begin
        if (rec_q != 8'h00) rec_d = rec_q - 8'h01;
        if (wtrs_q != 4'h0) wtrs_d = wtrs_q - 4'h1;
        if (wtrl_q != 4'h0) wtrl_d = wtrl_q - 4'h1;
      end
    end
    // Register port.
    rdata_d = 32'h0000_0000;
    if (re_i) begin
      unique case (addr_i)
        `A_CTRL: rdata_d = ctrl_q;
        `A_CMD:  rdata_d = cmdr_q;
        `A_DLO:  rdata_d = data_q[31:0];
        `A_DHI:  rdata_d = data_q[63:32];
        `A_STAT: rdata_d = {24'h0, en_q, wtrs_q != 4'h0 || wtrl_q != 4'h0,
                            rec_q != 8'h00, 4'(cnt_q), req_q};
        `A_TIME: rdata_d = time_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (we_i) begin
      unique case (addr_i)
        `A_CTRL: begin
          ctrl_d = wdata_i;
          ctrl_d[`F_REINIT] = 1'b0;
        end
        `A_CMD:  if (!req_q) begin
          cmdr_d = wdata_i;
          req_d = 1'b1;
        end
        `A_DLO:  data_d[31:0] = wdata_i;
        `A_DHI:  data_d[63:32] = wdata_i;
        `A_TIME: time_d = wdata_i;
        default: ;
      endcase
    end
    cnt_d = cnt_q + (push ? (PW+1)'(1) : '0) - (pop ? (PW+1)'(1) : '0);
    // Reinitialisation drops everything in flight.
    if (we_i && addr_i == `A_CTRL && wdata_i[`F_REINIT]) begin
      cnt_d = '0; rp_d = '0; wp_d = '0; req_d = 1'b0; arm_d = 1'b0;
      rec_d = 8'h00; wtrs_d = 4'h0; wtrl_d = 4'h0; space_d = 4'h0;
    end
  end

  // Registers of the controller.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 2'h0; ck_q <= 1'b0; h_q <= 8'h00; cmd_q <= 3'h0; bank_q <= 4'h0;
      chop_q <= 1'b0; ap_q <= 1'b0; space_q <= 4'h0; req_q <= 1'b0;
      ctrl_q <= `CTRL_RST; time_q <= `TIME_RST; cmdr_q <= 32'h0; data_q <= 64'h0;
      rec_q <= 8'h00; rbank_q <= 4'h0; wtrs_q <= 4'h0; wtrl_q <= 4'h0; wbg_q <= 2'h0;
      lb_q <= 4'h0; dq_q <= 8'h00; dqs_q <= 1'b0; en_q <= 1'b0; beat_q <= 1'b0;
      arm_q <= 1'b0; rp_q <= '0; wp_q <= '0; cnt_q <= '0; rdata_q <= 32'h0;
      for (int i = 0; i < DEPTH; i++) begin
        qs_q[i] <= 8'h00; qn_q[i] <= 4'h0; qb_q[i] <= 4'h0; qk_q[i] <= 4'h0;
        qd_q[i] <= 64'h0; qc_q[i] <= 8'h00;
      end
    end else begin
      div_q <= div_d; ck_q <= ck_d; h_q <= h_d; cmd_q <= cmd_d; bank_q <= bank_d;
      chop_q <= chop_d; ap_q <= ap_d; space_q <= space_d; req_q <= req_d;
      ctrl_q <= ctrl_d; time_q <= time_d; cmdr_q <= cmdr_d; data_q <= data_d;
      rec_q <= rec_d; rbank_q <= rbank_d; wtrs_q <= wtrs_d; wtrl_q <= wtrl_d;
      wbg_q <= wbg_d; lb_q <= lb_d; dq_q <= dq_d; dqs_q <= dqs_d; en_q <= en_d;
      beat_q <= beat_d; arm_q <= arm_d; rp_q <= rp_d; wp_q <= wp_d; cnt_q <= cnt_d;
      rdata_q <= rdata_d; qs_q <= qs_d; qn_q <= qn_d; qb_q <= qb_d; qk_q <= qk_d;
      qd_q <= qd_d; qc_q <= qc_d;
    end
  end

  // Every link wire comes from a flip-flop.
  assign link.ck = ck_q;
  assign link.dqs = dqs_q;
  assign link.dqs_en = en_q;
  assign link.cmd = cmd_q;
  assign link.bank = bank_q;
  assign link.chop = chop_q;
  assign link.ap = ap_q;
  assign link.dq = dq_q;
  assign rdata_o = rdata_q;
endmodule

`default_nettype wire

// ==== src/wcrc_defs.svh ====
// Purpose: Constants shared by the write link ends.
// Assumes: 50 MHz core clock, 160 ns link clock.
// Notes:   Register map applies to the controller port.
`ifndef WCRC_DEFS_SVH
`define WCRC_DEFS_SVH

// Link clock timing, derived from the two periods.
`define CLK_PERIOD_NS  20
`define LINK_PERIOD_NS 160
`define CK_HALF_CLKS   (`LINK_PERIOD_NS / (2 * `CLK_PERIOD_NS))

// Strobe and burst figures.
`define STROBE_GUARD   6
`define CRC_BEATS      4'h2
`define CWL_LOWEST     5'h09
`define SPACING_SHORT  4'h6
`define SPACING_PRE2   4'h7

// Controller register offsets.
`define A_CTRL 4'h0
`define A_CMD  4'h1
`define A_DLO  4'h2
`define A_DHI  4'h3
`define A_STAT 4'h4
`define A_TIME 4'h5

// Control register fields.
`define F_BMODE  1:0
`define F_CRC    2
`define F_DM     3
`define F_PRE2   4
`define F_CWL    12:8
`define F_SPACE  19:16
`define F_REINIT 31
`define CTRL_RST 32'h0005_0900

// Command register fields.
`define F_CTYPE 2:0
`define F_CBANK 7:4
`define F_CCHOP 8
`define F_CAP   9

// Timing register fields, in link clocks.
`define F_TWR     7:0
`define F_TWR_CDM 15:8
`define F_WTR_S   19:16
`define F_WTR_L   23:20
`define F_WTRS_CDM 27:24
`define F_WTRL_CDM 31:28
`define TIME_RST  32'h7362_0E0C

`endif

// ==== src/wcrc_dram.sv ====
// Purpose: Device end: takes write commands and strobed data.
// Assumes: Link wires are asynchronous and are synchronised here.
// Notes:   Link edges are counted in half link clocks.
`timescale 1ns/10ps
`default_nettype none

module wcrc_dram #(
  parameter int DEPTH = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  wcrc_link_if.dram        link,
  input  wire logic [1:0]  burst_mode_i,
  input  wire logic        crc_en_i,
  input  wire logic [4:0]  cwl_i,
  output logic             wr_done_o,
  output logic      [3:0]  wr_bank_o,
  output logic             wr_bad_o,
  output logic             crc_err_o,
  output logic             suspect_o,
  output logic             rd_valid_o,
  output logic      [3:0]  rd_bank_o,
  output logic      [63:0] rd_data_o
);
  localparam int PW = $clog2(DEPTH);

  wcrc_pkg::link_sample_t s1_q, s2_q;
  logic          ck3_q, dqs3_q;

  logic [7:0]    h_q, h_d;
  logic [7:0]    qs_q [DEPTH];
  logic [7:0]    qs_d [DEPTH];
  logic [3:0]    qb_q [DEPTH];
  logic [3:0]    qb_d [DEPTH];
  wcrc_pkg::burst_t qm_q [DEPTH];
  wcrc_pkg::burst_t qm_d [DEPTH];
  logic [PW-1:0] rp_q, rp_d, wp_q, wp_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic [3:0]    beat_q, beat_d;
  logic [63:0]   buf_q, buf_d;
  logic [7:0]    crc_q, crc_d;
  logic          done_q, done_d, bad_q, bad_d, cerr_q, cerr_d;
  logic          sus_q, sus_d, rv_q, rv_d;
  logic [3:0]    wb_q, wb_d, rb_q, rb_d;
  logic [63:0]   rdat_q, rdat_d;
  logic [63:0]   mem_q [16];
  logic          mem_we;
  logic [63:0]   mem_wd;

  logic          ck_rise, ck_edge, dqs_edge, pop, push;
  logic [7:0]    lag;
  logic [3:0]    slots, dbeats;
  wcrc_pkg::burst_t hb;

  // Two-stage synchroniser on every link wire; the third stage only
  // feeds the edge detectors on clock and strobe.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q   <= '0;
      s2_q   <= '0;
      ck3_q  <= 1'b0;
      dqs3_q <= 1'b0;
    end else begin
      s1_q   <= {link.ck, link.dqs, link.dqs_en, link.cmd, link.bank,
                 link.chop, link.ap, link.dq};
      s2_q   <= s1_q;
      ck3_q  <= s2_q.ck;
      dqs3_q <= s2_q.dqs;
    end
  end

  // Queue of accepted writes and the burst being gathered.
  always_comb begin
    h_d    = h_q;
    qs_d   = qs_q;
    qb_d   = qb_q;
    qm_d   = qm_q;
    rp_d   = rp_q;
    wp_d   = wp_q;
    beat_d = beat_q;
    buf_d  = buf_q;
    crc_d  = crc_q;
    done_d = 1'b0;
    bad_d  = 1'b0;
    cerr_d = 1'b0;
    wb_d   = wb_q;
    sus_d  = sus_q;
    rv_d   = 1'b0;
    rb_d   = rb_q;
    rdat_d = rdat_q;
    mem_we = 1'b0;
    mem_wd = buf_q;
    pop    = 1'b0;
    push   = 1'b0;
    ck_rise  = s2_q.ck & ~ck3_q;
    ck_edge  = s2_q.ck ^ ck3_q;
    dqs_edge = (s2_q.dqs ^ dqs3_q) & s2_q.dqs_en;
    if (ck_edge) h_d = h_q + 8'h01;
    hb     = qm_q[rp_q];
    slots  = wcrc_pkg::slot_beats(hb, crc_en_i);
    dbeats = (hb == wcrc_pkg::BURST_EIGHT) ? 4'h8 : 4'h4;
    lag    = h_q - qs_q[rp_q] - {4'h0, beat_q};

    // Commands are taken at the link clock rise; writes are queued
    // regardless of earlier faults, so a later burst is refused only when the queue is full.
    if (ck_rise) begin
      unique case (s2_q.cmd)
        wcrc_pkg::CMD_WR: if (cnt_q < (PW+1)'(DEPTH)) begin
          push = 1'b1;
          qs_d[wp_q] = h_d + {2'b00, cwl_i, 1'b0};
          qb_d[wp_q] = s2_q.bank;
          qm_d[wp_q] = wcrc_pkg::burst_select(burst_mode_i, s2_q.chop);
          wp_d = wp_q + PW'(1);
        end
        wcrc_pkg::CMD_RD: begin
          rv_d   = 1'b1;
          rb_d   = s2_q.bank;
          rdat_d = mem_q[s2_q.bank];
        end
        wcrc_pkg::CMD_PREA: sus_d = 1'b0;
        default: ;
      endcase
    end

    if (cnt_q != '0) begin
      // A strobe that never turns up within the guard drops only
      // this burst, so the queue cannot stall behind it.
      if ($signed(lag) > 8'sd`STROBE_GUARD) begin
        pop   = 1'b1;
        bad_d = 1'b1;
        wb_d  = qb_q[rp_q];
      end else if (dqs_edge && $signed(lag) >= -8'sd`STROBE_GUARD) begin
        // Data is taken as it stands; a setup or hold slip only
        // spoils the stored word.
        if (beat_q < dbeats) buf_d[{beat_q[2:0], 3'b000} +: 8] = s2_q.dq;
        else if (beat_q == slots - `CRC_BEATS) crc_d = s2_q.dq;
        beat_d = beat_q + 4'h1;
        if (beat_q == slots - 4'h1) begin
          pop    = 1'b1;
          done_d = 1'b1;
          wb_d   = qb_q[rp_q];
          mem_we = 1'b1;
          cerr_d = crc_en_i && (crc_q != wcrc_pkg::crc8(buf_q) || s2_q.dq != ~crc_q);
          if (!crc_en_i && beat_q < dbeats) buf_d[{beat_q[2:0], 3'b000} +: 8] = s2_q.dq;
          mem_wd = (hb == wcrc_pkg::BURST_EIGHT) ? buf_d
                 : {mem_q[qb_q[rp_q]][63:32], buf_d[31:0]};
        end
      end
    end
    if (pop) begin
      rp_d   = rp_q + PW'(1);
      beat_d = 4'h0;
      buf_d  = 64'hFFFF_FFFF_FFFF_FFFF;
    end
    // A dropped burst marks the device suspect; the mark wins over a
    // precharge-all seen in the same cycle.
    if (bad_d) sus_d = 1'b1;
    cnt_d = cnt_q + (push ? (PW+1)'(1) : '0) - (pop ? (PW+1)'(1) : '0);
  end

  // Registers of the queue, the burst and the user outputs.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      h_q    <= 8'h00;
      rp_q   <= '0;
      wp_q   <= '0;
      cnt_q  <= '0;
      beat_q <= 4'h0;
      buf_q  <= 64'hFFFF_FFFF_FFFF_FFFF;
      crc_q  <= 8'h00;
      done_q <= 1'b0;
      bad_q  <= 1'b0;
      cerr_q <= 1'b0;
      sus_q  <= 1'b0;
      rv_q   <= 1'b0;
      wb_q   <= 4'h0;
      rb_q   <= 4'h0;
      rdat_q <= 64'h0;
      for (int i = 0; i < DEPTH; i++) begin
        qs_q[i] <= 8'h00;
        qb_q[i] <= 4'h0;
        qm_q[i] <= wcrc_pkg::BURST_EIGHT;
      end
    end else begin
      h_q    <= h_d;
      rp_q   <= rp_d;
      wp_q   <= wp_d;
      cnt_q  <= cnt_d;
      beat_q <= beat_d;
      buf_q  <= buf_d;
      crc_q  <= crc_d;
      done_q <= done_d;
      bad_q  <= bad_d;
      cerr_q <= cerr_d;
      sus_q  <= sus_d;
      rv_q   <= rv_d;
      wb_q   <= wb_d;
      rb_q   <= rb_d;
      rdat_q <= rdat_d;
      qs_q   <= qs_d;
      qb_q   <= qb_d;
      qm_q   <= qm_d;
    end
  end

  // Storage array; it needs no reset, a read before any write is
  // simply undefined data.
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem_q[qb_q[rp_q]] <= mem_wd;
    end
  end

  // User outputs straight from flip-flops.
  assign wr_done_o  = done_q;
  assign wr_bank_o  = wb_q;
  assign wr_bad_o   = bad_q;
  assign crc_err_o  = cerr_q;
  assign suspect_o  = sus_q;
  assign rd_valid_o = rv_q;
  assign rd_bank_o  = rb_q;
  assign rd_data_o  = rdat_q;
endmodule

`default_nettype wire

// ==== src/wcrc_link_if.sv ====
// Purpose: Write link between controller and memory device.
// Assumes: Controller makes the link clock.
// Notes:   All wires are one-way, controller to device.
`timescale 1ns/10ps
`default_nettype none

interface wcrc_link_if;
  logic       ck;
  logic       dqs;
  logic       dqs_en;
  logic [2:0] cmd;
  logic [3:0] bank;
  logic       chop;
  logic       ap;
  logic [7:0] dq;

  modport ctrl (output ck, dqs, dqs_en, cmd, bank, chop, ap, dq);
  modport dram (input ck, dqs, dqs_en, cmd, bank, chop, ap, dq);
endinterface

`default_nettype wire

// ==== src/wcrc_pkg.sv ====
// Purpose: Types and helpers shared by both link ends.
// Assumes: Included defs header provides the figures.
// Notes:   Burst choice lives here so both ends agree.
`include "wcrc_defs.svh"

package wcrc_pkg;

  typedef enum logic [2:0] {
    CMD_NOP  = 3'b000,
    CMD_WR   = 3'b001,
    CMD_RD   = 3'b010,
    CMD_PRE  = 3'b011,
    CMD_PREA = 3'b100
  } link_cmd_t;

  typedef enum logic [1:0] {
    BURST_EIGHT = 2'b00,
    CHOP_OTF    = 2'b01,
    CHOP_FIXED  = 2'b10
  } burst_t;

  // One sampled copy of every link wire.
  typedef struct packed {
    logic       ck;
    logic       dqs;
    logic       dqs_en;
    logic [2:0] cmd;
    logic [3:0] bank;
    logic       chop;
    logic       ap;
    logic [7:0] dq;
  } link_sample_t;

  // Burst length from the mode field and the chop bit.
  function automatic burst_t burst_select(input logic [1:0] mode, input logic chop);
    burst_t b;
    b = BURST_EIGHT;
    if (mode == 2'h1 && !chop) b = CHOP_OTF;
    if (mode == 2'h2) b = CHOP_FIXED;
    return b;
  endfunction

  // Strobe slots of one burst, checksum beats included.
  function automatic logic [3:0] slot_beats(input burst_t b, input logic crc);
    logic [3:0] n;
    n = (b == CHOP_FIXED) ? 4'h4 : 4'h8;
    if (crc) n = n + `CRC_BEATS;
    return n;
  endfunction

  // Checksum over the eight data bytes, polynomial x8+x2+x+1.
  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 63; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

endpackage
